// >>> rtl/lcd_exec_pkg.sv
// constants and types shared by the display instruction executor
package lcd_exec_pkg;

	// ****************************************
	// clocking and execution timing
	// ****************************************
	localparam int CLK_KHZ = 20000; // system clock, 50 ns period
	localparam int OSC_KHZ = 270; // nominal internal oscillator rate
	localparam int OSC_DIV = CLK_KHZ / OSC_KHZ; // system cycles per oscillator tick
	localparam int EXEC_NS = 37000; // ordinary instruction time
	localparam int HOME_NS = 1520000; // clear display and return home time
	localparam int ADD_NS = 4000; // counter_update_delay after busy clears
	localparam int EXEC_TICKS = (EXEC_NS * OSC_KHZ + 999999) / 1000000;
	localparam int HOME_TICKS = (HOME_NS * OSC_KHZ + 999999) / 1000000;
	localparam int ADD_TICKS = (ADD_NS * OSC_KHZ + 999999) / 1000000;
	localparam int BLINK_US = 409600; // blink half period at the reference rate
	localparam int BLINK_REF_KHZ = 250;
	localparam int BLINK_TICKS = (BLINK_US * BLINK_REF_KHZ) / 1000;
	localparam int TICK_W = 12;

	// ****************************************
	// memory map of the address counter
	// ****************************************
	localparam int DRAM_DEPTH = 80;
	localparam int GRAM_DEPTH = 64;
	localparam logic [6:0] LINE1_LAST = 7'h27;
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [6:0] LINE2_LAST = 7'h67;
	localparam logic [6:0] ONE_LAST = 7'h4f;
	localparam logic [6:0] LINE2_TO_IDX = 7'h18; // 40H maps to index 40
	localparam logic [6:0] LINE_LEN = 7'h28;
	localparam logic [6:0] FULL_LEN = 7'h50;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [3:0] CURSOR_ROW_SMALL = 4'h7; // eighth row, counted from zero
	localparam logic [3:0] CURSOR_ROW_TALL = 4'ha; // eleventh row

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [6:0] AC_RST = 7'h00;
	localparam logic ENTRY_INC_RST = 1'b1;
	localparam logic AUTO_SHIFT_RST = 1'b0;
	localparam logic DISP_ON_RST = 1'b0;
	localparam logic CURSOR_ON_RST = 1'b0;
	localparam logic BLINK_ON_RST = 1'b0;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CLEAR = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_ADD_WAIT = 4'b1000
	} exec_state_type;

endpackage : lcd_exec_pkg

// >>> rtl/lcd_pin_sync.sv
// two-flop synchroniser for the host bus pins
`timescale 1ns/1ps
`default_nettype none
module lcd_pin_sync #(
	parameter int W = 11
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] pins_i,
	output logic [W-1:0] pins_o
);
	import lcd_exec_pkg::*;

	// ****************************************
	// one synchroniser per pin
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_r;
			logic sync_r;
			// first stage feeds only the second stage
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else if (ce_i) begin
					meta_r <= pins_i[g];
					sync_r <= meta_r;
				end
			end
			assign pins_o[g] = sync_r;
		end
	endgenerate
endmodule : lcd_pin_sync
`default_nettype wire

// >>> rtl/lcd_timebase.sv
// oscillator tick prescaler and cursor blink phase generator
`timescale 1ns/1ps
`default_nettype none
module lcd_timebase #(
	parameter int DIV = lcd_exec_pkg::OSC_DIV,
	parameter int BLINK = lcd_exec_pkg::BLINK_TICKS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic blink_en_i,
	output logic osc_tick_o,
	output logic blink_phase_o
);
	import lcd_exec_pkg::*;

	logic [7:0] div_r, div_nxt;
	logic [16:0] blink_cnt_r, blink_cnt_nxt;
	logic phase_r, phase_nxt;

	// ****************************************
	// next values
	// ****************************************
	// counting oscillator ticks keeps the blink rate tied to the oscillator
	always_comb begin
		div_nxt = div_r + 8'h01;
		blink_cnt_nxt = blink_cnt_r;
		phase_nxt = phase_r;
		osc_tick_o = 1'b0;
		if (div_r == 8'(DIV - 1)) begin
			div_nxt = 8'h00;
			osc_tick_o = 1'b1;
		end
		if (!blink_en_i) begin
			blink_cnt_nxt = 17'h00000; // restart so the phase starts normal
			phase_nxt = 1'b0;
		end else if (osc_tick_o) begin
			if (blink_cnt_r == 17'(BLINK - 1)) begin
				blink_cnt_nxt = 17'h00000;
				phase_nxt = ~phase_r;
			end else begin
				blink_cnt_nxt = blink_cnt_r + 17'h00001;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_r <= 8'h00;
			blink_cnt_r <= 17'h00000;
			phase_r <= 1'b0;
		end else if (ce_i) begin
			div_r <= div_nxt;
			blink_cnt_r <= blink_cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	assign blink_phase_o = phase_r;
endmodule : lcd_timebase
`default_nettype wire

// >>> rtl/lcd_instruction_executor.sv
// instruction executor of a character dot-matrix display controller
//
// Contract
// - data write with select high, read/write low stores byte in addressed RAM
// - data read with select high, read/write high returns byte from addressed RAM
// - counter steps by one after each RAM data write or read
// - counter step lands a short delay after busy clears
// - clear fills display RAM with spaces, zeroes counter and shift, sets increment
// - return home zeroes counter and shift, RAM untouched
// - direction bit one increments, zero decrements, for both RAMs
// - auto-shift on display write shifts left on increment, right on decrement
// - no auto-shift on display reads or any glyph access
// - display enable turns panel on or off, RAM contents kept
// - cursor is five dots on row eight or eleven, independent of entry mode
// - blink alternates blank and normal every 409.6 ms at 250 kHz
// - cursor/display shift command moves without any RAM access
// - two-line mode cursor passes from digit 40 onto line two
// - two-line display shift moves lines together, each wrapping within itself
// - display-only shift leaves counter unchanged
// - busy flag high while executing; host waits for low
// - shift code 00 cursor left, 01 right, 10 display left, 11 right
// - two-line addresses 00-27H and 40-67H; one-line 00-4FH
`timescale 1ns/1ps
`default_nettype none
module lcd_instruction_executor #(
	parameter int EXEC_TICKS = lcd_exec_pkg::EXEC_TICKS,
	parameter int HOME_TICKS = lcd_exec_pkg::HOME_TICKS,
	parameter int ADD_TICKS = lcd_exec_pkg::ADD_TICKS,
	parameter int BLINK_TICKS = lcd_exec_pkg::BLINK_TICKS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic reg_select_i,
	input wire logic rw_i,
	input wire logic enable_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_n_o,
	input wire logic two_line_i,
	input wire logic tall_font_i,
	input wire logic [6:0] scan_addr_i,
	output logic [7:0] scan_data_o,
	output logic busy_flag_o,
	output logic [6:0] addr_counter_o,
	output logic glyph_sel_o,
	output logic entry_inc_o,
	output logic auto_shift_o,
	output logic display_on_o,
	output logic cursor_on_o,
	output logic blink_on_o,
	output logic [3:0] cursor_row_o,
	output logic blink_blank_o,
	output logic [6:0] shift_offset_o
);
	import lcd_exec_pkg::*;

	// ****************************************
	// pin synchronisation and strobes
	// ****************************************
	logic [10:0] pins_s;
	logic rs_s, rw_s, en_s, en_d_r;
	logic [7:0] data_s;
	logic osc_tick, blink_phase;
	logic wr_stb, rd_stb;

	lcd_pin_sync #(
		.W(11)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.pins_i({reg_select_i, rw_i, enable_i, data_i}),
		.pins_o(pins_s)
	);

	assign {rs_s, rw_s, en_s, data_s} = pins_s;
	// writes latch on the falling enable edge, reads start on the rising one
	assign wr_stb = en_d_r & ~en_s & ~rw_s;
	assign rd_stb = ~en_d_r & en_s & rw_s;
	assign data_oe_n_o = ~(en_s & rw_s);

	// ****************************************
	// state
	// ****************************************
	exec_state_type state_r, state_nxt;
	logic [6:0] ac_r, ac_nxt;
	logic glyph_r, glyph_nxt;
	logic inc_r, inc_nxt;
	logic ashift_r, ashift_nxt;
	logic don_r, don_nxt;
	logic con_r, con_nxt;
	logic bon_r, bon_nxt;
	logic [6:0] shift_r, shift_nxt;
	logic [6:0] clr_idx_r, clr_idx_nxt;
	logic [TICK_W-1:0] tick_r, tick_nxt;
	logic [TICK_W-1:0] limit_r, limit_nxt;
	logic step_r, step_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic [7:0] scan_r;
	logic [7:0] dram [DRAM_DEPTH];
	logic [7:0] gram [GRAM_DEPTH];
	logic dram_we, gram_we;
	logic [6:0] dram_wa;
	logic [7:0] dram_wd;
	logic [6:0] ac_idx;

	// ****************************************
	// address helpers
	// ****************************************
	// next address in the entry direction, with line and window wrap
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
		input logic glyph, input logic two);
		logic [6:0] r;
		r = a;
		if (glyph) begin
			r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
		end else if (two) begin
			if (up) begin
				r = (a == LINE1_LAST) ? LINE2_BASE : (a == LINE2_LAST) ? 7'h00 : a + 7'h01;
			end else begin
				r = (a == 7'h00) ? LINE2_LAST : (a == LINE2_BASE) ? LINE1_LAST : a - 7'h01;
			end
		end else begin
			r = up ? ((a == ONE_LAST) ? 7'h00 : a + 7'h01) : ((a == 7'h00) ? ONE_LAST : a - 7'h01);
		end
		return r;
	endfunction : step_addr

	// display shift offset; in two-line mode each line wraps within 40 digits
	function automatic logic [6:0] shift_step(input logic [6:0] s, input logic left,
		input logic two);
		logic [6:0] len;
		len = two ? LINE_LEN : FULL_LEN;
		if (left) begin
			return (s >= len - 7'h01) ? 7'h00 : s + 7'h01;
		end
		return (s == 7'h00 || s >= len) ? len - 7'h01 : s - 7'h01;
	endfunction : shift_step

	// second line lives just after the first in the array
	assign ac_idx = (two_line_i && ac_r[6]) ? ac_r - LINE2_TO_IDX : ac_r;

	// ****************************************
	// instruction sequencer, next values
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		ac_nxt = ac_r;
		glyph_nxt = glyph_r;
		inc_nxt = inc_r;
		ashift_nxt = ashift_r;
		don_nxt = don_r;
		con_nxt = con_r;
		bon_nxt = bon_r;
		shift_nxt = shift_r;
		clr_idx_nxt = clr_idx_r;
		tick_nxt = tick_r;
		limit_nxt = limit_r;
		step_nxt = step_r;
		dout_nxt = dout_r;
		dram_we = 1'b0;
		gram_we = 1'b0;
		dram_wa = ac_idx;
		dram_wd = data_s;
		// status is readable in every state; the counter shows its old value until updated
		if (rd_stb && !rs_s) begin
			dout_nxt = {busy_flag_o, ac_r};
		end
		case (state_r)
			ST_IDLE: begin
				tick_nxt = '0;
				limit_nxt = TICK_W'(EXEC_TICKS);
				if (wr_stb && rs_s) begin
					// data write to whichever RAM was addressed last
					if (glyph_r) begin
						gram_we = 1'b1;
					end else begin
						dram_we = (ac_idx < 7'(DRAM_DEPTH));
						if (ashift_r) begin
							shift_nxt = shift_step(shift_r, inc_r, two_line_i);
						end
					end
					step_nxt = 1'b1;
					state_nxt = ST_EXEC;
				end else if (rd_stb && rs_s) begin
					// reads never shift the display
					if (glyph_r) begin
						dout_nxt = gram[ac_r[5:0]];
					end else begin
						dout_nxt = (ac_idx < 7'(DRAM_DEPTH)) ? dram[ac_idx] : 8'h00;
					end
					step_nxt = 1'b1;
					state_nxt = ST_EXEC;
				end else if (wr_stb) begin
					state_nxt = ST_EXEC;
					casez (data_s)
						8'b1???????: begin
							ac_nxt = data_s[6:0];
							glyph_nxt = 1'b0;
						end
						8'b01??????: begin
							ac_nxt = {1'b0, data_s[5:0]};
							glyph_nxt = 1'b1;
						end
						8'b001?????: begin
							// line count and font arrive as ports; only the time is spent
						end
						8'b0001????: begin
							// no RAM access here; cursor moves through the counter
							if (!data_s[3]) begin
								ac_nxt = step_addr(ac_r, data_s[2], glyph_r, two_line_i);
							end else begin
								shift_nxt = shift_step(shift_r, ~data_s[2], two_line_i);
							end
						end
						8'b00001???: begin
							don_nxt = data_s[2];
							con_nxt = data_s[1];
							bon_nxt = data_s[0];
						end
						8'b000001??: begin
							inc_nxt = data_s[1];
							ashift_nxt = data_s[0];
						end
						8'b0000001?: begin
							ac_nxt = AC_RST;
							glyph_nxt = 1'b0;
							shift_nxt = 7'h00;
							limit_nxt = TICK_W'(HOME_TICKS);
						end
						8'b00000001: begin
							ac_nxt = AC_RST;
							glyph_nxt = 1'b0;
							shift_nxt = 7'h00;
							inc_nxt = 1'b1;
							clr_idx_nxt = 7'h00;
							limit_nxt = TICK_W'(HOME_TICKS);
							state_nxt = ST_CLEAR;
						end
						default: begin
							state_nxt = ST_EXEC; // all-zero code only burns time
						end
					endcase
				end
			end
			ST_CLEAR: begin
				// one location per cycle, far inside the busy interval
				dram_we = 1'b1;
				dram_wa = clr_idx_r;
				dram_wd = SPACE_CODE;
				clr_idx_nxt = clr_idx_r + 7'h01;
				if (osc_tick) begin
					tick_nxt = tick_r + TICK_W'(1);
				end
				if (clr_idx_r == 7'(DRAM_DEPTH - 1)) begin
					state_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (osc_tick) begin
					tick_nxt = tick_r + TICK_W'(1);
					if (tick_r + TICK_W'(1) >= limit_r) begin
						tick_nxt = '0;
						state_nxt = step_r ? ST_ADD_WAIT : ST_IDLE;
					end
				end
			end
			ST_ADD_WAIT: begin
				// busy is already low; new instructions are ignored until the counter update
				if (osc_tick) begin
					tick_nxt = tick_r + TICK_W'(1);
					if (tick_r + TICK_W'(1) >= TICK_W'(ADD_TICKS)) begin
						ac_nxt = step_addr(ac_r, inc_r, glyph_r, two_line_i);
						step_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			ac_r <= AC_RST;
			glyph_r <= 1'b0;
			inc_r <= ENTRY_INC_RST;
			ashift_r <= AUTO_SHIFT_RST;
			don_r <= DISP_ON_RST;
			con_r <= CURSOR_ON_RST;
			bon_r <= BLINK_ON_RST;
			shift_r <= 7'h00;
			clr_idx_r <= 7'h00;
			tick_r <= '0;
			limit_r <= '0;
			step_r <= 1'b0;
			dout_r <= 8'h00;
			en_d_r <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			ac_r <= ac_nxt;
			glyph_r <= glyph_nxt;
			inc_r <= inc_nxt;
			ashift_r <= ashift_nxt;
			don_r <= don_nxt;
			con_r <= con_nxt;
			bon_r <= bon_nxt;
			shift_r <= shift_nxt;
			clr_idx_r <= clr_idx_nxt;
			tick_r <= tick_nxt;
			limit_r <= limit_nxt;
			step_r <= step_nxt;
			dout_r <= dout_nxt;
			en_d_r <= en_s;
		end
	end

	// ****************************************
	// memories and scan port
	// ****************************************
	// no reset on the arrays; contents survive display off
	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			if (dram_we) begin
				dram[dram_wa] <= dram_wd;
			end
			if (gram_we) begin
				gram[ac_r[5:0]] <= data_s;
			end
			scan_r <= (scan_addr_i < 7'(DRAM_DEPTH)) ? dram[scan_addr_i] : SPACE_CODE;
		end
	end

	lcd_timebase #(
		.DIV(OSC_DIV),
		.BLINK(BLINK_TICKS)
	) u_timebase (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.blink_en_i(bon_r),
		.osc_tick_o(osc_tick),
		.blink_phase_o(blink_phase)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign busy_flag_o = (state_r == ST_CLEAR) || (state_r == ST_EXEC);
	assign data_o = dout_r;
	assign scan_data_o = scan_r;
	assign addr_counter_o = ac_r;
	assign glyph_sel_o = glyph_r;
	assign entry_inc_o = inc_r;
	assign auto_shift_o = ashift_r;
	assign display_on_o = don_r;
	assign cursor_on_o = con_r;
	assign blink_on_o = bon_r;
	assign cursor_row_o = tall_font_i ? CURSOR_ROW_TALL : CURSOR_ROW_SMALL;
	assign blink_blank_o = bon_r & blink_phase;
	assign shift_offset_o = shift_r;
endmodule : lcd_instruction_executor
`default_nettype wire

// >>> tb/lcd_exec_monitor.sv
// assertion checker bound to the display instruction executor ports
`timescale 1ns/1ps
`default_nettype none
module lcd_exec_monitor (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_select_i,
	input wire logic rw_i,
	input wire logic enable_i,
	input wire logic two_line_i,
	input wire logic tall_font_i,
	input wire logic data_oe_n_o,
	input wire logic busy_flag_o,
	input wire logic [6:0] addr_counter_o,
	input wire logic glyph_sel_o,
	input wire logic entry_inc_o,
	input wire logic auto_shift_o,
	input wire logic display_on_o,
	input wire logic cursor_on_o,
	input wire logic blink_on_o,
	input wire logic [3:0] cursor_row_o,
	input wire logic blink_blank_o,
	input wire logic [6:0] shift_offset_o
);
	import lcd_exec_pkg::*;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	logic data_op_r;
	// ****************************************
	// helper state and sequences
	// ****************************************
	// instruction strobes clear the flag, refused or not, so later checks only go quiet, never misfire
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_op_r <= 1'b0;
		end else if ($fell(enable_i) && !rw_i) begin
			data_op_r <= reg_select_i;
		end else if ($rose(enable_i) && rw_i && reg_select_i) begin
			data_op_r <= 1'b1;
		end
	end
	sequence s_busy_start;
		$rose(busy_flag_o);
	endsequence
	sequence s_data_done;
		$fell(busy_flag_o) && data_op_r;
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_busy_min_hold: assert property (s_busy_start |-> busy_flag_o [*8])
		else $error("busy flag dropped too early");
	a_busy_max_len: assert property (s_busy_start |-> ##[1:600] !busy_flag_o)
		else $error("busy flag stuck high");
	a_oe_read_cause: assert property (!data_oe_n_o |-> $past(enable_i, 2) && $past(rw_i, 2))
		else $error("bus driven without a read strobe");
	a_oe_release: assert property ($fell(enable_i) |-> ##[1:3] data_oe_n_o)
		else $error("bus not released after strobe");
	a_counter_late: assert property (s_data_done |-> $stable(addr_counter_o) [*8])
		else $error("counter stepped too soon after busy");
	a_cursor_row: assert property (cursor_row_o ==
		(tall_font_i ? CURSOR_ROW_TALL : CURSOR_ROW_SMALL))
		else $error("cursor row wrong for font");
	a_shift_range: assert property (shift_offset_o <=
		(two_line_i ? LINE1_LAST : ONE_LAST))
		else $error("display shift out of line range");
	a_shift_in_exec: assert property ($changed(shift_offset_o) |->
		busy_flag_o || $past(busy_flag_o))
		else $error("display shift moved while idle");
	a_mode_in_exec: assert property ($changed({entry_inc_o, auto_shift_o,
		display_on_o, cursor_on_o, blink_on_o, glyph_sel_o}) |-> busy_flag_o || $past(busy_flag_o))
		else $error("mode bits changed while idle");
	a_blink_quiet: assert property (!blink_on_o |-> !blink_blank_o)
		else $error("blank phase without blink enabled");
endmodule : lcd_exec_monitor
bind lcd_instruction_executor lcd_exec_monitor u_monitor (.*);
`default_nettype wire

// >>> tb/lcd_host_model.sv
// host processor model driving the parallel bus pins
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	output logic reg_select_o,
	output logic rw_o,
	output logic enable_o,
	output logic [7:0] wdata_o
);
	initial begin
		reg_select_o = 1'b0;
		rw_o = 1'b1;
		enable_o = 1'b0;
		wdata_o = 8'h00;
	end
	// each phase held long enough for the two-flop pin sync; read byte taken before release
	task automatic strobe(input logic rs, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys_i);
		reg_select_o <= rs;
		rw_o <= rd;
		wdata_o <= d;
		enable_o <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		q = rdata_i;
		enable_o <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		wdata_o <= ~d; // released bus never keeps the last byte
		rw_o <= 1'b1;
	endtask : strobe
	// nothing new is sent until status shows idle; bounded so a hang is reported
	task automatic poll(output logic ok, output logic [7:0] st);
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++) begin
			strobe(1'b0, 1'b1, 8'h00, st);
			ok = (st[7] === 1'b0);
		end
	endtask : poll
endmodule : lcd_host_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the display instruction executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lcd_exec_pkg::*;
	localparam int TK = OSC_DIV;
	logic clk_sys_i, rst_n_i, ce_i, reg_select_i, rw_i, enable_i, two_line_i, tall_font_i;
	logic [7:0] data_i, data_o, scan_data_o, q, st0, sv;
	logic [6:0] scan_addr_i, addr_counter_o, shift_offset_o;
	logic [3:0] cursor_row_o;
	logic data_oe_n_o, busy_flag_o, glyph_sel_o, entry_inc_o, auto_shift_o, ok;
	logic display_on_o, cursor_on_o, blink_on_o, blink_blank_o;
	int n_mismatch = 0;
	int n_tests = 0;
	int n;
	// small tick counts keep the run short
	lcd_instruction_executor #(.EXEC_TICKS(2), .HOME_TICKS(3), .ADD_TICKS(2), .BLINK_TICKS(4))
		u_dut (.*);
	lcd_host_model u_host (.clk_sys_i(clk_sys_i), .rdata_i(data_o), .reg_select_o(reg_select_i),
		.rw_o(rw_i), .enable_o(enable_i), .wdata_o(data_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// transfer, poll to idle, then let the delayed counter step land
	task automatic xfer(input logic rs, input logic rd, input logic [7:0] d);
		u_host.strobe(rs, rd, d, q);
		u_host.poll(ok, st0);
		if (!ok) begin
			n_mismatch++;
			wrap_up();
		end
		repeat (3 * TK) @(posedge clk_sys_i);
	endtask : xfer
	task automatic scan(input logic [6:0] a);
		@(posedge clk_sys_i);
		scan_addr_i <= a;
		repeat (3) @(posedge clk_sys_i);
		sv = scan_data_o;
	endtask : scan
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_clear();
		xfer(1'b0, 1'b0, 8'h05); // decrement with auto shift
		xfer(1'b0, 1'b0, 8'h18);
		xfer(1'b0, 1'b0, 8'h01);
		chk("inc", 8'(entry_inc_o), 8'h01);
		chk("autoshift", 8'(auto_shift_o), 8'h01);
		chk("ac", 8'(addr_counter_o), 8'h00);
		chk("offset", 8'(shift_offset_o), 8'h00);
		for (int i = 0; i < 80; i += 13) begin
			scan(7'(i));
			chk("blank", sv, SPACE_CODE);
		end
	endtask : t_clear
	task automatic t_write();
		xfer(1'b0, 1'b0, 8'h06);
		xfer(1'b0, 1'b0, 8'ha6);
		xfer(1'b1, 1'b0, 8'h41);
		chk("ac early", st0 & 8'h7f, 8'h26);
		chk("ac", 8'(addr_counter_o), 8'h27);
		u_host.strobe(1'b1, 1'b0, 8'h42, q);
		xfer(1'b0, 1'b0, 8'h90); // sent while busy, must be dropped
		chk("ac wrap", 8'(addr_counter_o), 8'h40);
		xfer(1'b1, 1'b0, 8'h43);
		scan(7'd39);
		chk("ram", sv, 8'h42);
		scan(7'd40);
		chk("ram", sv, 8'h43);
	endtask : t_write
	task automatic t_read();
		xfer(1'b0, 1'b0, 8'h05);
		xfer(1'b0, 1'b0, 8'ha7);
		xfer(1'b1, 1'b1, 8'h00);
		chk("rd", q, 8'h42);
		chk("ac", 8'(addr_counter_o), 8'h26);
		chk("offset", 8'(shift_offset_o), 8'h00);
		xfer(1'b0, 1'b0, 8'h45);
		xfer(1'b1, 1'b0, 8'h1f);
		chk("glyph", 8'({glyph_sel_o, addr_counter_o}), 8'h84);
		chk("offset", 8'(shift_offset_o), 8'h00);
		xfer(1'b0, 1'b0, 8'h45);
		xfer(1'b1, 1'b1, 8'h00);
		chk("glyph rd", q, 8'h1f);
	endtask : t_read
	task automatic t_autoshift();
		xfer(1'b0, 1'b0, 8'h80);
		xfer(1'b1, 1'b0, 8'h44);
		chk("right", 8'(shift_offset_o), 8'h27);
		xfer(1'b0, 1'b0, 8'h07);
		xfer(1'b1, 1'b0, 8'h45);
		chk("left", 8'(shift_offset_o), 8'h00);
		xfer(1'b0, 1'b0, 8'h06);
		xfer(1'b1, 1'b0, 8'h46);
		chk("none", 8'(shift_offset_o), 8'h00);
	endtask : t_autoshift
	// cursor left, cursor right, display left, display right
	task automatic t_shift();
		xfer(1'b0, 1'b0, 8'h85);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, 1'b0, 8'h10 + 8'(i * 4));
			chk("ac", 8'(addr_counter_o), i == 0 ? 8'h04 : 8'h05);
			chk("offset", 8'(shift_offset_o), i == 2 ? 8'h01 : 8'h00);
		end
		xfer(1'b0, 1'b0, 8'h18);
		xfer(1'b0, 1'b0, 8'h02);
		chk("home", 8'({shift_offset_o == 7'h00, addr_counter_o}), 8'h80);
		scan(7'd38);
		chk("kept", sv, 8'h41);
	endtask : t_shift
	task automatic t_display();
		chk("row", 8'(cursor_row_o), 8'h07);
		xfer(1'b0, 1'b0, 8'h0f);
		chk("on", 8'({display_on_o, cursor_on_o, blink_on_o}), 8'h07);
		tall_font_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk("row", 8'(cursor_row_o), 8'h0a);
		n = 0;
		for (int i = 0; i < 2000 && blink_blank_o; i++) @(posedge clk_sys_i);
		for (int i = 0; i < 2000 && !blink_blank_o; i++) @(posedge clk_sys_i);
		// a used-up wait for the blank phase shows up here as a missing blank phase
		chk("blank seen", 8'(blink_blank_o), 8'h01);
		while (blink_blank_o && n < 2000) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk("blink", 8'((n + TK / 2) / TK), 8'h04);
		xfer(1'b0, 1'b0, 8'h08);
		chk("off", 8'({display_on_o, blink_blank_o}), 8'h00);
		scan(7'd38);
		chk("kept", sv, 8'h41);
	endtask : t_display
	task automatic t_oneline();
		two_line_i <= 1'b0;
		xfer(1'b0, 1'b0, 8'ha7);
		xfer(1'b1, 1'b0, 8'h47);
		chk("ac", 8'(addr_counter_o), 8'h28);
		scan(7'd39);
		chk("ram", sv, 8'h47);
	endtask : t_oneline
	// function set and the empty code only cost time; a strobe under a held clock enable is lost
	task automatic t_misc();
		xfer(1'b0, 1'b0, 8'h38);
		xfer(1'b0, 1'b0, 8'h00);
		chk("fn set", 8'({glyph_sel_o, addr_counter_o}), 8'h28);
		chk("fn shift", 8'(shift_offset_o), 8'h00);
		ce_i <= 1'b0;
		u_host.strobe(1'b1, 1'b0, 8'h55, q);
		ce_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk("frozen ac", 8'(addr_counter_o), 8'h28);
		chk("frozen busy", 8'(busy_flag_o), 8'h00);
		scan(7'd40);
		chk("frozen ram", sv, 8'h43);
	endtask : t_misc
	initial begin
		ce_i = 1'b1;
		rst_n_i = 1'b0;
		two_line_i = 1'b1;
		tall_font_i = 1'b0;
		scan_addr_i = 7'h00;
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		chk("reset", 8'({busy_flag_o, entry_inc_o, display_on_o}), 8'h02);
		t_clear();
		t_write();
		t_read();
		t_autoshift();
		t_shift();
		t_display();
		t_oneline();
		t_misc();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
